/* File: fast_read_defines.svh */
// Opcodes, field positions, reset values and counts of the fast read engine
`ifndef FAST_READ_DEFINES_SVH
`define FAST_READ_DEFINES_SVH

`define OP_QUAD_OUT 8'h6B
`define OP_DUAL_IO 8'hBB
`define OP_QUAD_IO 8'hEB
`define OP_WORD_QIO 8'hE7
`define OP_SET_WRAP 8'h77
`define OP_MODE_RST 8'hFF

`define CMD_BITS 8
`define ADDR_BITS 24
`define MODE_BITS 8
`define WRAP_ARG_CLKS 8
`define SKIP_MATCH 2'h2
`define MODE_SKIP_HI 5
`define MODE_SKIP_LO 4
`define WRAP_FIELD_HI 6
`define WRAP_FIELD_LO 4

`define DUMMY_QUAD_OUT 4'h8
`define DUMMY_QUAD_IO 4'h4
`define DUMMY_WORD_QIO 4'h2

`define WRAP_DIS_RESET 1'b1
`define WRAP_LEN_RESET 2'h0
`define IDLE_BYTE 8'hFF

`define FIFO_WIDTH 8
`define FIFO_DEPTH 4

`endif

/* File: fast_read_pkg.sv */
// Types shared by the fast read engine and its bench
package fast_read_pkg;

  // Command sequencer phases
  typedef enum logic [2:0] {
    ST_IDLE, ST_CMD, ST_ADDR, ST_MODE, ST_DUMMY, ST_DATA, ST_WRAP, ST_IGNORE
  } seq_state_t;

  // Lane count as a shift amount: 0 one line, 1 two lines, 2 four lines
  typedef logic [1:0] lane_log_t;

  // Stored burst wrap setting
  typedef struct packed {
    logic [1:0] wrap_length;
    logic wrap_disable;
  } wrap_bits_t;

  // Memory read answer
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } mem_rsp_t;

endpackage

/* File: byte_fifo.sv */
// Small synchronous FIFO with valid/ready on both sides and a flush
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic clk, // System clock
  input wire logic reset_n, // Synchronous reset, active low
  input wire logic flush, // Drops all content, wins over a push
  input wire logic in_valid, // Write request
  output logic in_ready, // Not full
  input wire logic [WIDTH-1:0] in_data, // Write data
  output logic out_valid, // Not empty
  input wire logic out_ready, // Pop request
  output logic [WIDTH-1:0] out_data // Head word, from storage flops
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  // Full and empty come straight from the fill count
  // Count is one bit wider than the pointers so a full buffer is visible
  assign in_ready = (cnt_q != (AW+1)'(DEPTH)) && !flush;
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready && !flush;

  // Storage
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  // Pointers and fill count
  always_ff @(posedge clk) begin
    if (!reset_n || flush) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

endmodule // byte_fifo

/* File: multi_io_fast_read_engine.sv */
// Multi-line fast read engine of a serial flash, sampled on the system clock
// Function
// - Quad output read refused without quad_enable
// - Quad output: serial command, address, eight dummies
// - Input lines ignored during dummy clocks
// - Dual I/O: address and data on two lines
// - Mode byte follows address; bits 5:4 count
// - Skip field 10: next dual read skips command
// - Other skip field: full command next time
// - All-ones mode reset ends continuous mode; mode bits cleared unless the mode byte completed
// - Quad I/O: four lines, four dummy clocks
// - Quad I/O read needs quad_enable
// - Quad I/O continuous read starts with address
// - Wrap confines quad I/O reads to page sections
// - Wrap returns to section start until deselect
// - Three wrap bits: disable and length
// - Word quad read: even address, two dummies
// - Word quad read needs quad_enable
// - Word quad continuous read starts with address
// - Wrap also applies to word quad reads
// - Length codes 8..64 bytes; wrap off at reset
// - Mode reset: eight or sixteen all-one clocks
`include "fast_read_defines.svh"
module multi_io_fast_read_engine
  import fast_read_pkg::*;
(
  input wire logic clk, // System clock, 200 MHz
  input wire logic reset_n, // Synchronous reset, active low
  input wire logic cs_n_pin, // Chip select pin, active low
  input wire logic sclk_pin, // Serial clock pin
  input wire logic [3:0] io_in, // IO line levels
  output logic [3:0] io_out, // IO drive values
  output logic [3:0] io_oe, // IO drive enables, high drives
  input wire logic quad_enable, // Status bit enabling quad reads
  output logic mem_rd_req, // Array read request
  output logic [23:0] mem_rd_addr, // Array read address
  input wire mem_rsp_t mem_rsp, // Array read answer
  output logic cont_mode, // Continuous read mode active
  output wrap_bits_t wrap_bits // Stored wrap setting
);

  // Two-flop synchronisers plus one history flop for edge detection
  logic cs_s1_q, cs_s2_q, cs_s3_q;
  logic ck_s1_q, ck_s2_q, ck_s3_q;
  logic [3:0] io_s1_q, io_s2_q;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      {cs_s1_q, cs_s2_q, cs_s3_q} <= 3'h7;
      {ck_s1_q, ck_s2_q, ck_s3_q} <= 3'h0;
      io_s1_q <= 4'h0;
      io_s2_q <= 4'h0;
    end else begin
      cs_s1_q <= cs_n_pin;
      cs_s2_q <= cs_s1_q;
      cs_s3_q <= cs_s2_q;
      ck_s1_q <= sclk_pin;
      ck_s2_q <= ck_s1_q;
      ck_s3_q <= ck_s2_q;
      io_s1_q <= io_in;
      io_s2_q <= io_s1_q;
    end
  end

  logic sel, rise, fall, cs_fall, cs_rise;
  assign sel = !cs_s2_q;
  assign rise = sel && ck_s2_q && !ck_s3_q;
  assign fall = sel && !ck_s2_q && ck_s3_q;
  assign cs_fall = !cs_s2_q && cs_s3_q;
  assign cs_rise = cs_s2_q && !cs_s3_q;

  // Lanes used for address and mode of a command
  function automatic lane_log_t addr_lanes(input logic [7:0] op);
    case (op)
      `OP_DUAL_IO: addr_lanes = 2'h1;
      `OP_QUAD_IO, `OP_WORD_QIO, `OP_SET_WRAP: addr_lanes = 2'h2;
      default: addr_lanes = 2'h0;
    endcase
  endfunction

  // Lanes used for read data of a command
  function automatic lane_log_t data_lanes(input logic [7:0] op);
    data_lanes = (op == `OP_DUAL_IO) ? 2'h1 : 2'h2;
  endfunction

  // Dummy clocks of a command after its address or mode byte
  function automatic logic [3:0] dummy_clks(input logic [7:0] op);
    case (op)
      `OP_QUAD_OUT: dummy_clks = `DUMMY_QUAD_OUT;
      `OP_QUAD_IO: dummy_clks = `DUMMY_QUAD_IO;
      `OP_WORD_QIO: dummy_clks = `DUMMY_WORD_QIO;
      default: dummy_clks = 4'h0;
    endcase
  endfunction

  seq_state_t st_q;
  logic [7:0] cmd_q, cont_cmd_q, mode_q;
  logic [31:0] sh_q;
  logic [4:0] cnt_q;
  logic [3:0] dcnt_q;
  logic ones_q, cont_q;
  wrap_bits_t wrap_q;
  lane_log_t alw, dlw;
  logic [31:0] sh_in;
  logic [7:0] cmd_in;
  logic [4:0] addr_last, mode_last;

  assign alw = addr_lanes(cmd_q);
  assign dlw = data_lanes(cmd_q);
  assign cmd_in = {cmd_q[6:0], io_s2_q[0]};
  assign addr_last = 5'(`ADDR_BITS >> alw) - 5'h1;
  assign mode_last = 5'(`MODE_BITS >> alw) - 5'h1;

  // Shift in one, two or four bits, lane 0 being the least significant
  always_comb begin
    case (alw)
      2'h1: sh_in = {sh_q[29:0], io_s2_q[1:0]};
      2'h2: sh_in = {sh_q[27:0], io_s2_q};
      default: sh_in = {sh_q[30:0], io_s2_q[0]};
    endcase
  end

  // Command sequencer, advanced on sampled rising edges of the serial clock
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st_q <= ST_IDLE;
      cmd_q <= 8'h00;
      cnt_q <= 5'h0;
      dcnt_q <= 4'h0;
      sh_q <= 32'h0;
    end else if (!sel) begin
      st_q <= ST_IDLE;
    end else if (cs_fall) begin
      cnt_q <= 5'h0;
      sh_q <= 32'h0;
      if (cont_q) begin
        st_q <= ST_ADDR;
        cmd_q <= cont_cmd_q;
      end else begin
        st_q <= ST_CMD;
      end
    end else if (rise) begin
      cnt_q <= cnt_q + 5'h1;
      case (st_q)
        ST_CMD: begin
          cmd_q <= cmd_in;
          if (cnt_q == 5'(`CMD_BITS - 1)) begin
            cnt_q <= 5'h0;
            case (cmd_in)
              `OP_QUAD_OUT, `OP_QUAD_IO, `OP_WORD_QIO: begin
                // Quad reads are refused while quad lines are disabled
                st_q <= quad_enable ? ST_ADDR : ST_IGNORE;
              end
              `OP_DUAL_IO: st_q <= ST_ADDR;
              `OP_SET_WRAP: st_q <= ST_WRAP;
              default: st_q <= ST_IGNORE;
            endcase
          end
        end
        ST_ADDR: begin
          sh_q <= sh_in;
          if (cnt_q == addr_last) begin
            cnt_q <= 5'h0;
            dcnt_q <= dummy_clks(cmd_q) - 4'h1;
            st_q <= (cmd_q == `OP_QUAD_OUT) ? ST_DUMMY : ST_MODE;
          end
        end
        ST_MODE: begin
          sh_q <= sh_in;
          if (cnt_q == mode_last) begin
            cnt_q <= 5'h0;
            dcnt_q <= dummy_clks(cmd_q) - 4'h1;
            st_q <= (cmd_q == `OP_DUAL_IO) ? ST_DATA : ST_DUMMY;
          end
        end
        ST_DUMMY: begin
          // Line levels are not looked at here
          dcnt_q <= dcnt_q - 4'h1;
          if (dcnt_q == 4'h0) begin
            st_q <= ST_DATA;
          end
        end
        ST_WRAP: begin
          sh_q <= sh_in;
          if (cnt_q == 5'(`WRAP_ARG_CLKS - 1)) begin
            st_q <= ST_IGNORE;
          end
        end
        default: st_q <= st_q;
      endcase
    end
  end

  // Mode bits and continuous mode, updated when the mode byte completes
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      mode_q <= 8'h00;
      cont_q <= 1'b0;
      cont_cmd_q <= 8'h00;
      ones_q <= 1'b1;
    end else begin
      if (cs_fall) begin
        ones_q <= 1'b1;
      end else if (rise && st_q == ST_ADDR && io_s2_q[0] == 1'b0) begin
        ones_q <= 1'b0;
      end
      if (rise && st_q == ST_MODE && cnt_q == mode_last) begin
        mode_q <= sh_in[7:0];
        cont_q <= (sh_in[`MODE_SKIP_HI:`MODE_SKIP_LO] == `SKIP_MATCH);
        cont_cmd_q <= cmd_q;
      end else if (rise && st_q == ST_CMD && cnt_q == 5'(`CMD_BITS - 1)
                   && cmd_in == `OP_MODE_RST) begin
        mode_q <= 8'h00;
        cont_q <= 1'b0;
      end else if (cs_rise && st_q == ST_ADDR && cont_q && ones_q) begin
        // Deselect mid address after all-ones clocks is the mode reset
        mode_q <= 8'h00;
        cont_q <= 1'b0;
      end
    end
  end

  // Wrap setting, taken from the last byte of the setup argument
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wrap_q <= '{wrap_length: `WRAP_LEN_RESET,
                  wrap_disable: `WRAP_DIS_RESET};
    end else if (rise && st_q == ST_WRAP
                 && cnt_q == 5'(`WRAP_ARG_CLKS - 1)) begin
      wrap_q <= sh_in[`WRAP_FIELD_HI:`WRAP_FIELD_LO];
    end
  end

  assign cont_mode = cont_q;
  assign wrap_bits = wrap_q;

  // Wrap applies only to quad I/O and word quad I/O reads
  logic wrap_on;
  logic [23:0] wrap_mask;
  assign wrap_on = !wrap_q.wrap_disable
                   && (cmd_q == `OP_QUAD_IO || cmd_q == `OP_WORD_QIO);
  assign wrap_mask = (24'h000008 << wrap_q.wrap_length) - 24'h000001;

  // Next array address, modulo the section when wrapping
  function automatic logic [23:0] next_addr(input logic [23:0] a,
                                            input logic on,
                                            input logic [23:0] m);
    logic [23:0] inc;
    inc = a + 24'h1;
    next_addr = on ? ((a & ~m) | (inc & m)) : inc;
  endfunction

  // Array prefetch into the byte buffer; one request outstanding at a time
  logic fetch_on_q, busy_q, stale_q;
  logic [23:0] fetch_q;
  logic fifo_in_ready, fifo_out_valid, fifo_pop, flush;
  logic [7:0] fifo_out_data;
  logic addr_done;

  assign flush = !sel;
  assign addr_done = rise && st_q == ST_ADDR && cnt_q == addr_last;
  // Stalls while the buffer is full, so a slow host only slows the fetch
  assign mem_rd_req = fetch_on_q && fifo_in_ready && !busy_q && sel;
  assign mem_rd_addr = fetch_q;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      fetch_on_q <= 1'b0;
      fetch_q <= 24'h0;
      busy_q <= 1'b0;
      stale_q <= 1'b0;
    end else begin
      if (mem_rsp.valid) begin
        busy_q <= 1'b0;
        stale_q <= 1'b0;
      end else if (mem_rd_req) begin
        busy_q <= 1'b1;
      end
      // An answer still on its way when the frame ends is dropped
      if (flush && (busy_q || mem_rd_req) && !mem_rsp.valid) begin
        stale_q <= 1'b1;
      end
      if (flush) begin
        fetch_on_q <= 1'b0;
      end else if (addr_done) begin
        fetch_on_q <= 1'b1;
        fetch_q <= sh_in[23:0];
      end else if (mem_rd_req) begin
        fetch_q <= next_addr(fetch_q, wrap_on, wrap_mask);
      end
    end
  end

  byte_fifo #(
    .WIDTH(`FIFO_WIDTH),
    .DEPTH(`FIFO_DEPTH)
  ) u_buf (
    .clk(clk),
    .reset_n(reset_n),
    .flush(flush),
    .in_valid(mem_rsp.valid && fetch_on_q && !stale_q),
    .in_ready(fifo_in_ready),
    .in_data(mem_rsp.data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out_data)
  );

  // Data shifter, driven on sampled falling edges of the serial clock
  logic [7:0] oreg_q;
  logic [2:0] obit_q;
  logic [7:0] byte_now;
  logic [3:0] lane_mask;

  assign fifo_pop = fall && st_q == ST_DATA && obit_q == 3'h0;
  // An empty buffer shows as erased data rather than stalling the host
  assign byte_now = fifo_out_valid ? fifo_out_data : `IDLE_BYTE;
  assign lane_mask = (dlw == 2'h1) ? 4'h3 : 4'hF;

  always_ff @(posedge clk) begin
    if (!reset_n || !sel) begin
      oreg_q <= 8'h00;
      obit_q <= 3'h0;
      io_out <= 4'h0;
      io_oe <= 4'h0;
    end else if (fall && st_q == ST_DATA) begin
      io_oe <= lane_mask;
      if (obit_q == 3'h0) begin
        obit_q <= (dlw == 2'h1) ? 3'h3 : 3'h1;
        if (dlw == 2'h1) begin
          io_out <= {2'h0, byte_now[7:6]};
          oreg_q <= {byte_now[5:0], 2'h0};
        end else begin
          io_out <= byte_now[7:4];
          oreg_q <= {byte_now[3:0], 4'h0};
        end
      end else begin
        obit_q <= obit_q - 3'h1;
        if (dlw == 2'h1) begin
          io_out <= {2'h0, oreg_q[7:6]};
          oreg_q <= {oreg_q[5:0], 2'h0};
        end else begin
          io_out <= oreg_q[7:4];
          oreg_q <= {oreg_q[3:0], 4'h0};
        end
      end
    end
  end

  property p_quad_refused;
    @(posedge clk) disable iff (!reset_n)
    (rise && st_q == ST_CMD && cnt_q == 5'h7 && !quad_enable
     && cmd_in == `OP_QUAD_OUT) |=> st_q == ST_IGNORE;
  endproperty
  a_quad_refused: assert property (p_quad_refused)
    else $error("quad output read taken without quad_enable");

  property p_qio_refused;
    @(posedge clk) disable iff (!reset_n)
    (rise && st_q == ST_CMD && cnt_q == 5'h7 && !quad_enable
     && (cmd_in == `OP_QUAD_IO || cmd_in == `OP_WORD_QIO))
    |=> st_q == ST_IGNORE ##1 io_oe == 4'h0;
  endproperty
  a_qio_refused: assert property (p_qio_refused)
    else $error("quad I/O read taken without quad_enable");

  property p_dummy_quiet;
    @(posedge clk) disable iff (!reset_n)
    st_q == ST_DUMMY |-> io_oe == 4'h0 && !fifo_pop;
  endproperty
  a_dummy_quiet: assert property (p_dummy_quiet)
    else $error("lines driven during dummy clocks");

  property p_skip_cmd;
    @(posedge clk) disable iff (!reset_n)
    (cs_fall && cont_q) |=> st_q == ST_ADDR && cmd_q == $past(cont_cmd_q);
  endproperty
  a_skip_cmd: assert property (p_skip_cmd)
    else $error("continuous read did not start at address");

  property p_leave_cont;
    @(posedge clk) disable iff (!reset_n)
    (rise && st_q == ST_MODE && cnt_q == mode_last
     && sh_in[5:4] != 2'h2) |=> !cont_q ##1 (!cs_fall || st_q != ST_ADDR);
  endproperty
  a_leave_cont: assert property (p_leave_cont)
    else $error("continuous mode kept with other skip field");

  property p_mode_reset;
    @(posedge clk) disable iff (!reset_n)
    (cs_rise && st_q == ST_ADDR && cont_q && ones_q) |=> !cont_q
      && mode_q == 8'h00;
  endproperty
  a_mode_reset: assert property (p_mode_reset)
    else $error("all-ones clocks did not leave continuous mode");

  property p_dual_lanes;
    @(posedge clk) disable iff (!reset_n)
    (st_q == ST_DATA && cmd_q == `OP_DUAL_IO && io_oe != 4'h0)
    |-> io_oe == 4'h3 && io_out[3:2] == 2'h0;
  endproperty
  a_dual_lanes: assert property (p_dual_lanes)
    else $error("dual read drives upper lines");

  property p_word_dummy;
    @(posedge clk) disable iff (!reset_n)
    (rise && st_q == ST_MODE && cnt_q == mode_last && cmd_q == `OP_WORD_QIO)
    |=> st_q == ST_DUMMY && dcnt_q == 4'h1;
  endproperty
  a_word_dummy: assert property (p_word_dummy)
    else $error("word quad read dummy count wrong");

  property p_wrap_section;
    @(posedge clk) disable iff (!reset_n)
    (mem_rd_req && wrap_on && !addr_done && sel) |=>
      (mem_rd_addr & ~wrap_mask) == ($past(mem_rd_addr) & ~$past(wrap_mask));
  endproperty
  a_wrap_section: assert property (p_wrap_section)
    else $error("wrapped read left its section");

endmodule // multi_io_fast_read_engine

/* File: spi_host_model.sv */
// Behavioural SPI host that frames chip select, clocks sclk and drives io
module spi_host_model #(
  parameter int HALF = 6
) (
  input wire logic clk, // System clock
  output logic cs_n, // Chip select, active low
  output logic sclk, // Serial clock, idles low outside frames
  output logic [3:0] io_drv, // Host drive values
  output logic [3:0] io_en, // Host drive enables, high drives
  input wire logic [3:0] io_line // Resolved line levels
);
  timeunit 1ns;
  timeprecision 100ps;

  // Idle levels from time zero
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    io_drv = 4'h0;
    io_en = 4'h0;
  end

  // Open a frame with sclk low, as mode 0 wants
  task automatic sel();
    @(posedge clk);
    #1 cs_n = 1'b0;
  endtask

  // One serial clock: lines set in the low phase, sampled at the rise
  task automatic cyc(input logic [3:0] v, input logic [3:0] en,
                     output logic [3:0] s);
    io_drv = v;
    io_en = en;
    repeat (HALF) @(posedge clk);
    #1 sclk = 1'b1;
    s = io_line;
    repeat (HALF) @(posedge clk);
    #1 sclk = 1'b0;
  endtask

  // Let go of the lines at once, since the device may start driving
  task automatic desel();
    io_en = 4'h0;
    repeat (HALF) @(posedge clk);
    #1 cs_n = 1'b1;
    repeat (4 * HALF) @(posedge clk);
    #1;
  endtask
endmodule // spi_host_model

/* File: multi_io_fast_read_engine_bench.sv */
// Self-checking bench of the multi-line fast read engine
`include "fast_read_defines.svh"
module multi_io_fast_read_engine_bench
  import fast_read_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk;
  logic reset_n;
  logic quad_enable;
  mem_rsp_t mem_rsp;
  logic [3:0] io_out, io_oe, io_in, host_drv, host_en;
  logic [3:0] flt_q = 4'h5;
  logic cs_n, sclk, mem_rd_req, cont_mode;
  logic [23:0] mem_rd_addr, addr_s, pend_a;
  wrap_bits_t wrap_bits;
  logic req_s;
  int wait_c = 0;
  int fail_count = 0;
  int checked = 0;
  logic wdis_m = 1'b1;
  logic [1:0] wlen_m = 2'h0;
  bit cont_m = 1'b0;
  logic [7:0] ops [4] = '{`OP_QUAD_OUT, `OP_DUAL_IO, `OP_QUAD_IO,
                          `OP_WORD_QIO};

  multi_io_fast_read_engine DUT (.clk(clk), .reset_n(reset_n),
    .cs_n_pin(cs_n), .sclk_pin(sclk), .io_in(io_in), .io_out(io_out),
    .io_oe(io_oe), .quad_enable(quad_enable), .mem_rd_req(mem_rd_req),
    .mem_rd_addr(mem_rd_addr), .mem_rsp(mem_rsp), .cont_mode(cont_mode),
    .wrap_bits(wrap_bits));

  spi_host_model HOST (.clk(clk), .cs_n(cs_n), .sclk(sclk),
    .io_drv(host_drv), .io_en(host_en), .io_line(io_in));

  // Undriven lines toggle so a stale value never reads as good data
  assign io_in = (host_en & host_drv) | (~host_en & io_oe & io_out) |
                 (~host_en & ~io_oe & flt_q);

  // Float pattern
  always @(posedge clk) flt_q <= ~flt_q;

  // Clock at 200 MHz
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Array contents as a function of the address
  function automatic logic [7:0] mem_byte(input logic [23:0] a);
    return a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'h3C;
  endfunction

  // Even random address, usable by the word read too
  function automatic logic [23:0] ra();
    return 24'($urandom) & 24'hFFFFFE;
  endfunction

  task automatic check(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic report_and_stop();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Array model: one read outstanding, latency of 1 to 3 cycles
  always @(negedge clk) begin
    req_s = mem_rd_req;
    addr_s = mem_rd_addr;
  end
  initial begin
    mem_rsp = '0;
    forever begin
      @(posedge clk);
      #1;
      mem_rsp.valid = (wait_c == 1);
      mem_rsp.data = (wait_c == 1) ? mem_byte(pend_a) : 8'($urandom);
      if (wait_c != 0) wait_c--;
      if (req_s === 1'b1 && reset_n === 1'b1) begin
        pend_a = addr_s;
        wait_c = $urandom_range(3, 1);
      end
    end
  end

  // Host and device must never drive one line together
  always @(negedge clk) begin
    if (reset_n === 1'b1 && (host_en & io_oe) != 4'h0)
      check("io_clash", 4'h0, host_en & io_oe);
  end

  // Shift nb bits MSB first, w lines per clock, lane 0 least significant
  task automatic send(input logic [31:0] v, input int nb, input int w);
    logic [3:0] s;
    logic [3:0] m;
    m = 4'((1 << w) - 1);
    for (int k = nb - w; k >= 0; k -= w)
      HOST.cyc(4'(v >> k) & m, m, s);
  endtask

  // One read frame, compared byte by byte with the model
  task automatic rd(input logic [7:0] op, input bit skip,
                    input logic [23:0] a, input logic [7:0] m, input int nb);
    int aw, dw, dm, sz;
    bit ok, wr;
    logic [3:0] s;
    logic [7:0] b;
    logic [23:0] x;
    aw = (op == `OP_QUAD_OUT) ? 1 : (op == `OP_DUAL_IO) ? 2 : 4;
    dw = (op == `OP_DUAL_IO) ? 2 : 4;
    dm = (op == `OP_QUAD_OUT) ? 8 : (op == `OP_QUAD_IO) ? 4 :
         (op == `OP_WORD_QIO) ? 2 : 0;
    ok = quad_enable || op == `OP_DUAL_IO;
    wr = !wdis_m && (op == `OP_QUAD_IO || op == `OP_WORD_QIO);
    sz = 8 << wlen_m;
    HOST.sel();
    if (!skip) send(op, 8, 1);
    send(a, 24, aw);
    if (op != `OP_QUAD_OUT) send(m, 8, aw);
    for (int k = 0; k < dm; k++)
      HOST.cyc(4'($urandom), (k < dm - 1) ? 4'hF : 4'h0, s);
    for (int i = 0; i < nb; i++) begin
      for (int c = 0; c < 8 / dw; c++) begin
        HOST.cyc(4'h0, 4'h0, s);
        b = (dw == 2) ? {b[5:0], s[1:0]} : {b[3:0], s};
        check("io_oe", ok ? ((dw == 2) ? 4'h3 : 4'hF) : 4'h0, io_oe);
      end
      x = wr ? ((a & ~24'(sz - 1)) | ((a + 24'(i)) & 24'(sz - 1))) :
          a + 24'(i);
      if (ok) check("data", mem_byte(x), b);
    end
    HOST.desel();
    if (ok && op != `OP_QUAD_OUT) cont_m = (m[5:4] == 2'b10);
    check("cont_mode", cont_m, cont_mode);
  endtask

  // Burst wrap setup: command, 24 dummy bits, then the wrap byte
  task automatic set_wrap(input logic [1:0] len, input logic dis);
    HOST.sel();
    send(`OP_SET_WRAP, 8, 1);
    send({24'($urandom), 1'b0, len, dis, 4'h0}, 32, 4);
    HOST.desel();
    wlen_m = len;
    wdis_m = dis;
    check("wrap_bits", {len, dis}, wrap_bits);
  endtask

  // All-ones clocks in continuous mode, then deselect
  task automatic mode_rst(input int n);
    logic [3:0] s;
    HOST.sel();
    for (int k = 0; k < n; k++)
      HOST.cyc(4'hF, 4'hF, s);
    HOST.desel();
    cont_m = 1'b0;
    check("cont_mode", 1'b0, cont_mode);
  endtask

  // Main sequence
  initial begin
    void'($urandom(88179));
    reset_n = 1'b0;
    quad_enable = 1'b0;
    repeat (20) @(posedge clk);
    #1 reset_n = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    check("io_oe", 4'h0, io_oe);
    check("cont_mode", 1'b0, cont_mode);
    check("wrap_bits", {`WRAP_LEN_RESET, `WRAP_DIS_RESET}, wrap_bits);
    for (int q = 0; q < 2; q++) begin
      #0 quad_enable = 1'(q);
      for (int i = 0; i < 4; i++)
        rd(ops[i], 0, ra(), {2'($urandom), 2'b00, 4'($urandom)}, 5);
    end
    for (int i = 1; i < 4; i++) begin
      rd(ops[i], 0, ra(), {2'($urandom), 2'b10, 4'($urandom)}, 3);
      rd(ops[i], 1, ra(), {2'($urandom), 2'b10, 4'($urandom)}, 3);
      rd(ops[i], 1, ra(), 8'h00, 3);
      rd(ops[i], 0, ra(), 8'h20, 2);
      // Short all-ones burst: deselect lands inside the address phase
      mode_rst(4);
      rd(ops[i], 0, ra(), 8'h20, 2);
      mode_rst((i == 1) ? 16 : 8);
      rd(ops[i], 0, ra(), 8'h00, 2);
    end
    for (int l = 0; l < 4; l++) begin
      set_wrap(2'(l), 1'b0);
      rd(`OP_QUAD_IO, 0, ra(), 8'h00, (8 << l) + 3);
      rd(`OP_WORD_QIO, 0, ra(), 8'h00, (8 << l) + 3);
    end
    rd(`OP_QUAD_OUT, 0, ra(), 8'h00, 12);
    set_wrap(2'h0, 1'b1);
    rd(`OP_QUAD_IO, 0, ra(), 8'h00, 12);
    report_and_stop();
  end

  // Watchdog, about four times the expected run
  initial begin
    repeat (80000) @(posedge clk);
    fail_count++;
    report_and_stop();
  end
endmodule // multi_io_fast_read_engine_bench
